// ---- verilog/shbp_defs.svh ----
// constants for the slave host buffer port: status layout, vector, pins
`ifndef SHBP_DEFS_SVH
`define SHBP_DEFS_SVH
`define SHBP_ST_OUT_FULL 0
`define SHBP_ST_IN_FULL 1
`define SHBP_ST_USER_F0 2
`define SHBP_ST_CMD_DATA 3
`define SHBP_ST_USER_LO 4
`define SHBP_ST_USER_HI 7
`define SHBP_IRQ_VECTOR 12'h003
`define SHBP_PIN_OUT_FULL 4
`define SHBP_PIN_IN_FULL 5
`define SHBP_PIN_DMA_REQ 6
`define SHBP_PIN_DMA_ACK 7
`define SHBP_BYTE_RESET 8'h00
`endif

// ---- verilog/shbp_pkg.sv ----
// types for the slave host buffer port
`default_nettype none
package shbp_pkg;
  typedef logic [7:0] shbp_byte_t;
  // internal processor flag operations on the two user flags
  typedef enum logic [1:0] {
    SHBP_FLAG_NONE,
    SHBP_FLAG_CLEAR,
    SHBP_FLAG_TOGGLE
  } shbp_flag_op_t;
  // state of the input-full interrupt sequencer
  typedef enum logic [0:0] {
    SHBP_IRQ_IDLE,
    SHBP_IRQ_IN_SERVICE
  } shbp_irq_state_t;
endpackage
`default_nettype wire

// ---- verilog/shbp_flag_bus.sv ----
// interface carrying the host-side strobes from pin sync into the core
`timescale 1ns/1ps
`default_nettype none
interface shbp_flag_bus;
  logic rd_pulse;
  logic wr_pulse;
  logic sel_line;
  logic [7:0] wr_data;
  modport sync (output rd_pulse, output wr_pulse, output sel_line,
    output wr_data);
  modport core (input rd_pulse, input wr_pulse, input sel_line,
    input wr_data);
endinterface
`default_nettype wire

// ---- verilog/shbp_pin_sync.sv ----
// pin synchroniser and strobe edge detector for the master bus
`timescale 1ns/1ps
`default_nettype none
module shbp_pin_sync (
  input wire logic core_clk, // controller clock
  input wire logic nrst, // async reset, active low
  input wire logic cs_n, // chip select pin
  input wire logic sel_pin, // register select pin
  input wire logic rd_n, // read strobe pin
  input wire logic wr_n, // write strobe pin
  input wire logic [7:0] data_pin, // data bus input
  input wire logic dma_ack_in_pin, // dma acknowledge pin
  input wire logic dma_en, // dma handshake lines enabled
  shbp_flag_bus.sync bus // synchronised strobes
);
  logic [4:0] s1;
  logic [4:0] s2;
  logic [7:0] d1;
  logic [7:0] d2;
  logic rd_prev;
  logic wr_prev;
  wire ack_on = dma_en & s2[4];
  // acknowledge forces select and register-select low internally
  wire cs_eff = ~s2[0] | ack_on;
  wire sel_eff = s2[1] & ~ack_on;
  wire rd_act = cs_eff & ~s2[2];
  wire wr_act = cs_eff & ~s2[3];

  // two stages on every pin; data is latched on the strobe's trailing edge later
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1 <= 5'h0F;
      s2 <= 5'h0F;
      d1 <= 8'h00;
      d2 <= 8'h00;
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
    end else begin
      s1 <= {dma_ack_in_pin, wr_n, rd_n, sel_pin, cs_n};
      s2 <= s1;
      d1 <= data_pin;
      d2 <= d1;
      rd_prev <= rd_act;
      wr_prev <= wr_act;
    end
  end

  // act once, on the trailing edge of each strobe
  assign bus.rd_pulse = rd_prev & ~rd_act;
  assign bus.wr_pulse = wr_prev & ~wr_act;
  assign bus.sel_line = sel_eff;
  assign bus.wr_data = d2;
endmodule // shbp_pin_sync
`default_nettype wire

// ---- verilog/shbp_host_port.sv ----
// host-side buffer port: status, input and output buffers, interrupt
// What this block does
// - three byte registers: status, input, output
// - decode select, register-select, read, write strobes
// - bit 0 out-full: set on load, clear on read
// - bit 1 in-full: set master write, clear read
// - processor reads input only when in-full set
// - user flag zero owned by internal processor
// - cmd/data flag captures register-select on write
// - upper four status bits loaded by processor
// - processor tests flags, cannot read them
// - processor checks out-full before loading output
// - enabled in-full interrupt calls vector 03H
// - write during service sets pending, recalls later
// - return-restore rearms the input-full interrupt
// - disable keeps pending; call or reset clears
// - flag pins show out-full, in-full on port2
// - dma request/acknowledge on port2 bits 6,7
`timescale 1ns/1ps
`default_nettype none
`include "shbp_defs.svh"
module shbp_host_port
  import shbp_pkg::*;
(
  input wire logic core_clk, // controller clock, 250 MHz
  input wire logic nrst, // async reset, active low
  input wire logic cs_n, // master chip select, active low
  input wire logic sel_pin, // register select line
  input wire logic rd_n, // master read strobe, active low
  input wire logic wr_n, // master write strobe, active low
  input wire logic [7:0] data_in, // master data bus in
  output logic [7:0] data_out, // master data bus out
  output logic data_oe, // high while driving the data bus
  input wire logic dma_ack_in_pin, // port2 bit7 dma acknowledge pin
  output logic [3:0] port2_hi, // port2 bits 7..4 alternate outputs
  output logic [3:0] port2_hi_oe, // enables for port2 bits 7..4
  input wire logic cpu_wr_out, // processor loads output buffer
  input wire logic [7:0] cpu_acc, // processor accumulator
  input wire logic cpu_rd_in, // processor reads input buffer
  output logic [7:0] cpu_in_data, // input buffer to processor
  input wire logic cpu_ld_status, // processor loads status bits 7..4
  input wire shbp_flag_op_t cpu_f0_op, // clear or toggle flag zero
  input wire shbp_flag_op_t cpu_f1_op, // clear or toggle cmd/data flag
  input wire logic cpu_irq_en, // in-full interrupt enable op
  input wire logic cpu_irq_dis, // in-full interrupt disable op
  input wire logic cpu_return_restore_op, // return-restore executed
  input wire logic cpu_flags_en, // host interrupt pins enable op
  input wire logic cpu_dma_en, // dma handshake enable op
  input wire logic cpu_dma_req, // processor raises dma request
  output logic test_out_full, // branch test: out-full
  output logic test_in_full, // branch test: in-full
  output logic test_f0, // branch test: flag zero
  output logic test_f1, // branch test: cmd/data flag
  output logic call_req, // one-cycle vectored call request
  output logic [11:0] call_vector // vector address of the call
);
  ////////////////////////////////////////////////////////////////////
  // pin side
  shbp_flag_bus hb();
  logic dma_en;
  shbp_pin_sync u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .cs_n(cs_n),
    .sel_pin(sel_pin),
    .rd_n(rd_n),
    .wr_n(wr_n),
    .data_pin(data_in),
    .dma_ack_in_pin(dma_ack_in_pin),
    .dma_en(dma_en),
    .bus(hb.sync)
  );

  ////////////////////////////////////////////////////////////////////
  // registers and flags
  shbp_byte_t in_buf; // host_in_buffer
  shbp_byte_t out_buf; // host_out_buffer
  logic out_full_flag;
  logic in_full_flag;
  logic user_flag_zero;
  logic cmd_data_flag;
  logic [3:0] user_bits;
  logic irq_en;
  logic pending;
  logic flags_en;
  logic dma_req;
  shbp_irq_state_t irq_state;

  // read decode: low select reads output buffer, high reads status
  wire rd_out = hb.rd_pulse & ~hb.sel_line;
  wire [7:0] status = {user_bits, cmd_data_flag, user_flag_zero,
    in_full_flag, out_full_flag};
  wire [7:0] next_data = hb.sel_line ? status : out_buf;

  // read data is registered every cycle from the select line and the registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      data_out <= `SHBP_BYTE_RESET;
    end else begin
      data_out <= next_data;
    end
  end

  // the bus is driven only while a selected read strobe is low; the pins
  // get their own two stages so no gate sits ahead of the synchroniser
  logic [2:0] oe_s1; // {ack, read strobe, select} first stage
  logic [2:0] oe_s2;
  wire rd_level = (~oe_s2[0] | (dma_en & oe_s2[2])) & ~oe_s2[1];
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      oe_s1 <= 3'h3;
      oe_s2 <= 3'h3;
      data_oe <= 1'b0;
    end else begin
      oe_s1 <= {dma_ack_in_pin, rd_n, cs_n};
      oe_s2 <= oe_s1;
      data_oe <= rd_level;
    end
  end

  // host writes land in the input buffer while selected, at any register-select level
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      in_buf <= `SHBP_BYTE_RESET;
      out_buf <= `SHBP_BYTE_RESET;
      user_bits <= 4'h0;
    end else begin
      if (hb.wr_pulse) in_buf <= hb.wr_data;
      if (cpu_wr_out) out_buf <= cpu_acc;
      if (cpu_ld_status) user_bits <= cpu_acc[7:4];
    end
  end

  // set wins over clear for both handshake flags
  wire next_out_full = cpu_wr_out | (out_full_flag & ~rd_out);
  wire next_in_full = hb.wr_pulse | (in_full_flag & ~cpu_rd_in);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      out_full_flag <= 1'b0;
      in_full_flag <= 1'b0;
    end else begin
      out_full_flag <= next_out_full;
      in_full_flag <= next_in_full;
    end
  end

  // user flags; a host write capture of select beats the processor op
  function automatic logic flag_step(input logic cur,
    input shbp_flag_op_t op);
    flag_step = (op == SHBP_FLAG_CLEAR) ? 1'b0 :
      (op == SHBP_FLAG_TOGGLE) ? ~cur : cur;
  endfunction
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      user_flag_zero <= 1'b0;
      cmd_data_flag <= 1'b0;
    end else begin
      user_flag_zero <= flag_step(user_flag_zero, cpu_f0_op);
      if (hb.wr_pulse) cmd_data_flag <= hb.sel_line;
      else cmd_data_flag <= flag_step(cmd_data_flag, cpu_f1_op);
    end
  end

  // processor sees the flags only as branch conditions
  assign test_out_full = out_full_flag;
  assign test_in_full = in_full_flag;
  assign test_f0 = user_flag_zero;
  assign test_f1 = cmd_data_flag;
  assign cpu_in_data = in_buf;

  ////////////////////////////////////////////////////////////////////
  // input-full interrupt
  wire irq_hit = hb.wr_pulse & irq_en;
  wire fire_idle = (irq_state == SHBP_IRQ_IDLE) & (irq_hit | pending);
  wire fire_ret = (irq_state == SHBP_IRQ_IN_SERVICE) & cpu_return_restore_op &
    (pending | irq_hit);
  wire fire = fire_idle | fire_ret;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_en <= 1'b0;
    end else if (cpu_irq_en) begin
      irq_en <= 1'b1;
    end else if (cpu_irq_dis) begin
      irq_en <= 1'b0;
    end
  end

  // pending survives a disable; only the call itself or reset clears it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pending <= 1'b0;
    end else if (fire) begin
      pending <= 1'b0;
    end else if (irq_hit & (irq_state == SHBP_IRQ_IN_SERVICE)) begin
      pending <= 1'b1;
    end
  end

  // service state: entered by the call, left by return-restore
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_state <= SHBP_IRQ_IDLE;
      call_req <= 1'b0;
    end else begin
      call_req <= fire;
      case (irq_state)
        SHBP_IRQ_IDLE: begin
          if (fire) irq_state <= SHBP_IRQ_IN_SERVICE;
        end
        SHBP_IRQ_IN_SERVICE: begin
          if (cpu_return_restore_op && !fire) irq_state <= SHBP_IRQ_IDLE;
        end
        default: irq_state <= SHBP_IRQ_IDLE;
      endcase
    end
  end
  assign call_vector = `SHBP_IRQ_VECTOR;

  ////////////////////////////////////////////////////////////////////
  // port2 alternate functions
  logic dma_ack_in_a;
  logic dma_ack_in_sync;
  wire ack_now = hb.wr_pulse | hb.rd_pulse;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flags_en <= 1'b0;
      dma_en <= 1'b0;
      dma_req <= 1'b0;
    end else begin
      if (cpu_flags_en) flags_en <= 1'b1;
      if (cpu_dma_en) dma_en <= 1'b1;
      if (cpu_dma_req) dma_req <= 1'b1;
      else if (dma_en & ack_now & dma_ack_in_sync) dma_req <= 1'b0;
    end
  end

  // acknowledge sampled through two stages before use
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dma_ack_in_a <= 1'b0;
      dma_ack_in_sync <= 1'b0;
    end else begin
      dma_ack_in_a <= dma_ack_in_pin;
      dma_ack_in_sync <= dma_ack_in_a;
    end
  end

  // outputs registered; bit 7 is an input so its enable stays low
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      port2_hi <= 4'h0;
      port2_hi_oe <= 4'h0;
    end else begin
      port2_hi <= {1'b0, dma_req, next_in_full, next_out_full};
      port2_hi_oe <= {1'b0, dma_en, flags_en, flags_en};
    end
  end
endmodule // shbp_host_port
`default_nettype wire

// ---- testbench/shbp_host_port_asserts.sv ----
// checker for host port flag, call and pin timing
`timescale 1ns/1ps
`default_nettype none
module shbp_host_port_chk (
  input wire logic core_clk, // clock
  input wire logic nrst, // reset, active low
  input wire logic cs_n, // master select
  input wire logic wr_n, // master write strobe
  input wire logic rd_n, // master read strobe
  input wire logic dma_ack_in_pin, // dma acknowledge
  input wire logic data_oe, // bus drive enable
  input wire logic [3:0] port2_hi, // port2 upper pins
  input wire logic [3:0] port2_hi_oe, // their enables
  input wire logic cpu_wr_out, // output buffer load
  input wire logic cpu_rd_in, // input buffer read
  input wire logic cpu_dma_req, // dma request raise
  input wire logic test_out_full, // out-full level
  input wire logic test_in_full, // in-full level
  input wire logic call_req, // vectored call
  input wire logic [11:0] call_vector // call address
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  //////////////////////////////////////////////////////////////////////////
  // call and flag relations
  chk_vec_fixed: assert property (call_req |-> call_vector == 12'h003)
    else $error("call vector wrong");
  chk_call_single: assert property (call_req |=> !call_req)
    else $error("call request longer than one cycle");
  chk_out_set: assert property (cpu_wr_out |=> test_out_full)
    else $error("out-full not set by load");
  // write strobe idle long enough that no host write can race the read
  chk_in_clear: assert property (wr_n[*8] ##0 cpu_rd_in |=> !test_in_full)
    else $error("in-full not cleared by read");
  // pins and flags load from the same next value, so no skew is allowed
  chk_pin_flags: assert property (
    port2_hi_oe[0] |-> port2_hi[1:0] == {test_in_full, test_out_full})
    else $error("flag pins differ from flags");
  chk_reset_clear: assert property (disable iff (1'b0)
    !nrst |-> !test_in_full && !test_out_full && !call_req
    && port2_hi_oe == 4'h0)
    else $error("state not cleared in reset");
  chk_no_select: assert property ((cs_n && !dma_ack_in_pin)[*8] |-> !data_oe)
    else $error("bus driven while unselected");
  chk_oe_read: assert property ((!cs_n && !rd_n)[*5] |-> data_oe)
    else $error("bus not driven during selected read");
  // request pin is registered twice after the raise pulse
  chk_dma_rise: assert property (
    $rose(port2_hi[2]) |-> $past(cpu_dma_req, 2))
    else $error("dma request rose without cause");
endmodule // shbp_host_port_chk
bind shbp_host_port shbp_host_port_chk u_chk (.core_clk, .nrst, .cs_n,
  .wr_n, .rd_n, .dma_ack_in_pin, .data_oe, .port2_hi, .port2_hi_oe, .cpu_wr_out,
  .cpu_rd_in, .cpu_dma_req, .test_out_full, .test_in_full, .call_req,
  .call_vector);
`default_nettype wire

// ---- testbench/shbp_master_model.sv ----
// master processor model on the host bus pins
`timescale 1ns/1ps
`default_nettype none
module shbp_master_model (
  input wire logic core_clk, // clock
  input wire logic [7:0] data_out, // device data
  output logic cs_n, // select
  output logic sel_pin, // register select
  output logic rd_n, // read strobe
  output logic wr_n, // write strobe
  output logic [7:0] data_in // write data
);
  initial begin
    {cs_n, rd_n, wr_n, sel_pin} = 4'hE;
    data_in = 8'h00;
  end
  // one access: strobe low 5 clocks, data held past the trailing edge
  task automatic xfer(input logic act, wr, sel, input logic [7:0] d,
      output logic [7:0] q);
    @(negedge core_clk);
    cs_n = !act;
    sel_pin = sel;
    data_in = d;
    rd_n = wr;
    wr_n = !wr;
    repeat (5) @(negedge core_clk);
    q = data_out; // settled half a cycle after its launching edge
    {cs_n, rd_n, wr_n} = 3'b111;
    repeat (4) @(negedge core_clk);
    data_in = ~d; // released bus has no keeper
    repeat (2) @(negedge core_clk);
  endtask
  // write once the input buffer is drained, or after 40 status polls
  task automatic put(input logic sel, input logic [7:0] d);
    logic [7:0] s = 8'h02;
    for (int n = 0; n < 40 && s[1]; n++) xfer(1, 0, 1, 8'h00, s);
    xfer(1, 1, sel, d, s);
  endtask
  // read the output buffer once it is full, or after 40 status polls
  task automatic get(output logic [7:0] q);
    logic [7:0] s = 8'h00;
    for (int n = 0; n < 40 && !s[0]; n++) xfer(1, 0, 1, 8'h00, s);
    xfer(1, 0, 0, 8'h00, q);
  endtask
endmodule // shbp_master_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the host buffer port
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import shbp_pkg::*;
;
  logic core_clk, nrst, dma_ack_in_pin, cs_n, sel_pin, rd_n, wr_n, data_oe, s;
  logic [7:0] data_in, data_out, cpu_acc, cpu_in_data, q, d, e;
  logic [3:0] p2, p2_oe;
  logic [8:0] cp;
  shbp_flag_op_t f0_op, f1_op;
  logic t_of, t_if, t_f0, t_f1, call_req;
  logic [11:0] call_vector;
  int mismatches, samples_checked, calls;
  logic [16:0] rows [4] = '{17'h15A0A, 17'h0A502, 17'h1FF0A, 17'h00002};
  shbp_host_port u_dut (.core_clk, .nrst, .cs_n, .sel_pin, .rd_n, .wr_n,
    .data_in, .data_out, .data_oe, .dma_ack_in_pin, .port2_hi(p2),
    .port2_hi_oe(p2_oe), .cpu_wr_out(cp[0]), .cpu_acc, .cpu_rd_in(cp[1]),
    .cpu_in_data, .cpu_ld_status(cp[2]), .cpu_f0_op(f0_op),
    .cpu_f1_op(f1_op), .cpu_irq_en(cp[3]), .cpu_irq_dis(cp[4]),
    .cpu_return_restore_op(cp[5]), .cpu_flags_en(cp[6]), .cpu_dma_en(cp[7]),
    .cpu_dma_req(cp[8]), .test_out_full(t_of), .test_in_full(t_if),
    .test_f0(t_f0), .test_f1(t_f1), .call_req, .call_vector);
  shbp_master_model u_mst (.core_clk, .data_out, .cs_n, .sel_pin, .rd_n,
    .wr_n, .data_in);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (call_req === 1'b1) calls++;
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [11:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one-cycle processor pulse; waits out the flag update
  task automatic pls(input int i);
    @(negedge core_clk) cp[i] = 1'b1;
    @(negedge core_clk) cp[i] = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic fop(input shbp_flag_op_t a, b);
    @(negedge core_clk) {f0_op, f1_op} = {a, b};
    @(negedge core_clk) {f0_op, f1_op} = {SHBP_FLAG_NONE, SHBP_FLAG_NONE};
    @(negedge core_clk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    final_report();
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, dma_ack_in_pin, cp, cpu_acc} = 0;
    {f0_op, f1_op} = {SHBP_FLAG_NONE, SHBP_FLAG_NONE};
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    nrst = 1'b1;
    repeat (4) @(negedge core_clk);
    chk("flags", {t_of, t_if, t_f0, t_f1, call_req, p2_oe}, 0);
    u_mst.xfer(1, 0, 1, 8'h00, q);
    chk("status", q, 8'h00);
    // write, status, processor read per row
    foreach (rows[i]) begin
      {s, d, e} = rows[i];
      u_mst.put(s, d);
      u_mst.xfer(1, 0, 1, 8'h00, q);
      chk("status", q, e);
      chk("cpu_in", cpu_in_data, d);
      pls(1);
      chk("in_full", t_if, 0);
    end
    u_mst.xfer(0, 1, 1, 8'h77, q);
    chk("unselected", t_if, 0);
    chk("unsel_buf", cpu_in_data, 8'h00);
    cpu_acc = 8'hC3;
    pls(0);
    chk("out_full", t_of, 1);
    u_mst.get(q);
    chk("out_buf", {t_of, q}, 12'h0C3);
    cpu_acc = 8'h9F;
    pls(2);
    fop(SHBP_FLAG_TOGGLE, SHBP_FLAG_NONE);
    u_mst.xfer(1, 0, 1, 8'h00, q);
    chk("status", q, 8'h94);
    fop(SHBP_FLAG_CLEAR, SHBP_FLAG_TOGGLE);
    u_mst.xfer(1, 0, 1, 8'h00, q);
    chk("status", {t_f0, t_f1, q}, 12'h198);
    fop(SHBP_FLAG_NONE, SHBP_FLAG_CLEAR);
    chk("f1_clear", {t_f0, t_f1}, 2'h0);
    // interrupt: call, rearm, pending through disable
    pls(3);
    u_mst.put(0, 8'h11);
    chk("calls", calls, 1);
    pls(1);
    pls(5);
    u_mst.put(0, 8'h22);
    chk("calls", calls, 2);
    pls(1);
    u_mst.put(0, 8'h33);
    pls(4);
    chk("calls", calls, 2);
    pls(5);
    chk("calls", calls, 3);
    pls(1);
    pls(5);
    u_mst.put(0, 8'h44);
    chk("calls", calls, 3);
    pls(1);
    // flag pins, then dma handshake
    pls(6);
    pls(0);
    chk("pins", {p2_oe[1:0], p2[1:0]}, 4'hD);
    u_mst.get(q);
    pls(7);
    pls(8);
    chk("dma_req", {p2_oe[2], p2[2]}, 2'h3);
    cpu_acc = 8'h6E;
    pls(0);
    dma_ack_in_pin = 1'b1;
    u_mst.xfer(0, 0, 1, 8'h00, q);
    dma_ack_in_pin = 1'b0;
    chk("dma_read", {p2[2], t_of, q}, 12'h06E);
    pls(0);
    nrst = 1'b0;
    @(negedge core_clk);
    chk("reset", {t_of, p2_oe, p2}, 0);
    nrst = 1'b1;
    repeat (3) @(negedge core_clk);
    u_mst.xfer(1, 0, 1, 8'h00, q);
    chk("status", q, 8'h00);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
